// file: tb/channel_mode_pin_control_bench.sv
// Self-checking bench for cmpc_top with the board model on its pins.
// Assumes a single AHB-Lite master and one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH at %0t: got %h want %h", $time, a, b); end end
module channel_mode_pin_control_bench;
  import cmpc_pkg::*;
  typedef struct packed {
    cmpc_pins_t p;
    logic [5:0] rx;
    logic [5:0] txp;
    logic [5:0] etx;
    logic [5:0] erx;
  } cmpc_row_t;
  // Pin order: pattern, comma, swap, relay ace, relay bdf, sgmii
  localparam cmpc_row_t ROWS [6] = '{'{6'b000000, 6'h07, 6'h0a, 6'h0a, 6'h07}, '{6'b001000, 6'h07, 6'h0a, 6'h05, 6'h0b},
    '{6'b000100, 6'h07, 6'h0a, 6'h0b, 6'h07}, '{6'b001010, 6'h07, 6'h0a, 6'h0f, 6'h0b},
    '{6'b000110, 6'h07, 6'h0a, 6'h0b, 6'h07}, '{6'b000010, 6'h38, 6'h0a, 6'h20, 6'h38}};
  logic mclk = 1'b0;
  logic reset, loop_en, hsel, hwrite, sgmii_mode, irq, hreadyout, hresp;
  logic [5:0] flip, comma_locked;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  cmpc_pins_t pin_req, pins;
  cmpc_lane_in_t lane_req, lane_in;
  cmpc_lane_out_t lane_out;
  int n_fail = 0;
  int n_tests = 0;
  always #20 mclk = ~mclk;
  cmpc_board u_board (.mclk(mclk), .pin_req(pin_req), .loop_en(loop_en), .flip(flip), .lane_req(lane_req),
    .tx_line(lane_out.tx_serial), .pins(pins), .lane_in(lane_in));
  cmpc_top u_dut (.mclk(mclk), .reset(reset), .pins(pins), .lane_in(lane_in), .lane_out(lane_out),
    .comma_locked(comma_locked), .sgmii_mode(sgmii_mode), .irq(irq), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // One single transfer; waits on ready in both phases
  task automatic ahb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    reset <= 1'b1;
    pin_req <= 6'b000001;
    loop_en <= 1'b0;
    flip <= 6'h00;
    lane_req <= '0;
    hsel <= 1'b0;
    haddr <= 32'h0000_0000;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= WORD_ZERO;
    cyc(20);
    reset <= 1'b0;
    cyc(4);
    `CHK(sgmii_mode, 1'b1)
    ahb(REG_MODE, 1'b0, WORD_ZERO);
    `CHK(rd, 32'h0000_0010)
    ahb(REG_CTRL, 1'b0, WORD_ZERO);
    `CHK(rd, 32'h0000_0001)
    ahb(8'h40, 1'b0, WORD_ZERO);
    `CHK(rd, WORD_ZERO)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      pin_req <= ROWS[i].p;
      lane_req <= {ROWS[i].rx, ROWS[i].txp};
      cyc(6);
      `CHK(lane_out.tx_serial, ROWS[i].etx)
      `CHK(lane_out.rx_parallel, ROWS[i].erx)
    end
    $display("test pin routing done");
    pin_req <= '0;
    lane_req <= {6'h07, 6'h0a};
    ahb(REG_SWAP, 1'b1, 32'h0000_0002);
    cyc(3);
    `CHK(lane_out.tx_serial, 6'h06)
    `CHK(lane_out.rx_parallel, 6'h0b)
    ahb(REG_SWAP, 1'b1, WORD_ZERO);
    ahb(REG_RELAY, 1'b1, 32'h0000_0001);
    cyc(3);
    `CHK(lane_out.tx_serial, 6'h0b)
    // Receive levels chosen so that relaying onto E and F differs from their own parallel bits
    lane_req.rx_serial <= 6'h38;
    ahb(REG_RELAY, 1'b1, 32'h0000_0030);
    cyc(3);
    `CHK(lane_out.tx_serial, 6'h3a)
    ahb(REG_RELAY, 1'b1, WORD_ZERO);
    $display("test register routing done");
    pin_req <= 6'b010000;
    lane_req <= '0;
    cyc(10);
    `CHK(comma_locked, 6'h00)
    ahb(REG_PINS, 1'b0, WORD_ZERO);
    `CHK(rd, 32'h0000_0002)
    for (int i = 6; i >= 0; i--) begin
      lane_req.rx_serial <= {6{COMMA_CODE7[i]}};
      cyc(1);
    end
    lane_req <= '0;
    // Board register, four shifts into the match window, then the lock flop
    cyc(6);
    `CHK(comma_locked, 6'h3f)
    ahb(REG_CTRL, 1'b1, WORD_ZERO);
    cyc(3);
    `CHK(comma_locked, 6'h00)
    ahb(REG_CTRL, 1'b1, 32'h0000_0001);
    $display("test comma done");
    ahb(REG_IRQ_EN, 1'b1, 32'h0000_003f);
    pin_req <= 6'b100000;
    loop_en <= 1'b1;
    cyc(40);
    ahb(REG_IRQ_CLR, 1'b1, 32'h0000_003f);
    cyc(4);
    ahb(REG_IRQ_STAT, 1'b0, WORD_ZERO);
    `CHK(rd, WORD_ZERO)
    `CHK(irq, 1'b0)
    ahb(REG_PRBS_ERR, 1'b0, WORD_ZERO);
    `CHK(rd, WORD_ZERO)
    flip <= 6'h01;
    cyc(1);
    flip <= 6'h00;
    cyc(20);
    ahb(REG_IRQ_STAT, 1'b0, WORD_ZERO);
    `CHK(rd, 32'h0000_0001)
    `CHK(irq, 1'b1)
    ahb(REG_IRQ_EN, 1'b1, WORD_ZERO);
    cyc(2);
    `CHK(irq, 1'b0)
    ahb(REG_IRQ_CLR, 1'b1, 32'h0000_0001);
    ahb(REG_IRQ_STAT, 1'b0, WORD_ZERO);
    `CHK(rd, WORD_ZERO)
    $display("test pattern done");
    pin_req <= '0;
    loop_en <= 1'b0;
    ahb(REG_CTRL, 1'b1, WORD_ZERO);
    reset <= 1'b1;
    cyc(6);
    reset <= 1'b0;
    cyc(4);
    `CHK(sgmii_mode, 1'b0)
    ahb(REG_CTRL, 1'b0, WORD_ZERO);
    `CHK(rd, 32'h0000_0001)
    $display("test second reset done");
    complete_run();
  end
endmodule : channel_mode_pin_control_bench
`undef CHK
`default_nettype wire

// file: tb/cmpc_board.sv
// Board model: strap pin levels and a serial loop from transmit back to receive.
// Assumes the bench asks for levels just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module cmpc_board (
  input wire logic mclk,
  input wire cmpc_pkg::cmpc_pins_t pin_req,
  input wire logic loop_en,
  input wire logic [5:0] flip,
  input wire cmpc_pkg::cmpc_lane_in_t lane_req,
  input wire logic [5:0] tx_line,
  output var cmpc_pkg::cmpc_pins_t pins,
  output var cmpc_pkg::cmpc_lane_in_t lane_in
);
  import cmpc_pkg::*;
  initial begin
    pins = '0;
    lane_in = '0;
  end
  // Straps move only on an edge, so the block sees clean levels
  always @(posedge mclk) begin
    pins <= pin_req;
    lane_in.tx_parallel <= lane_req.tx_parallel;
    // Loop lets the receive checker see the generator; flip corrupts bits
    lane_in.rx_serial <= loop_en ? (tx_line ^ flip) : lane_req.rx_serial;
  end
endmodule : cmpc_board
`default_nettype wire

// file: tb/cmpc_sva.sv
// Port checker for the mode pin control block, bound into cmpc_top.
// Assumes relay register bits stay clear while the swap pin routes.
`timescale 1ns/100ps
`default_nettype none
module cmpc_sva #(
  parameter int NCH = cmpc_pkg::NUM_CH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire cmpc_pkg::cmpc_pins_t pins,
  input wire cmpc_pkg::cmpc_lane_in_t lane_in,
  input wire cmpc_pkg::cmpc_lane_out_t lane_out,
  input wire logic [NCH-1:0] comma_locked,
  input wire logic sgmii_mode,
  input wire logic irq,
  input wire logic hreadyout,
  input wire logic hresp
);
  import cmpc_pkg::*;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [4:0] pat_cnt;
  logic [3:0] run_len;
  logic [2:0] up_cnt;
  logic last_tx;
  wire logic ok = (up_cnt == 3'h7);
  function automatic logic [5:0] sw(input logic [5:0] v);
    return {v[4], v[5], v[2], v[3], v[0], v[1]};
  endfunction : sw
  always_ff @(posedge mclk) begin
    if (reset) begin
      pat_cnt <= 5'h00;
      run_len <= 4'h0;
      up_cnt <= 3'h0;
      last_tx <= 1'b0;
    end else begin
      pat_cnt <= !pins.pattern_test_enable_pin ? 5'h00 : ((pat_cnt == 5'h1f) ? pat_cnt : pat_cnt + 5'h01);
      run_len <= (lane_out.tx_serial[0] != last_tx) ? 4'h1 : ((run_len == 4'hf) ? run_len : run_len + 4'h1);
      up_cnt <= ok ? up_cnt : up_cnt + 3'h1;
      last_tx <= lane_out.tx_serial[0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |-> lane_out == '0 && comma_locked == '0 && !irq)
    else $error("outputs not cleared by reset");
  a_swap_rx_route: assert property (ok && $past(pins.swap_pin, 3) |->
    lane_out.rx_parallel == sw($past(lane_in.rx_serial))) else $error("receive swap wrong");
  a_swap_tx_route: assert property (ok && $past(pins.swap_pin, 3) && !$past(pins.relay_pin_ace, 3) &&
    !$past(pins.relay_pin_bdf, 3) && !$past(pins.pattern_test_enable_pin, 3) |->
    lane_out.tx_serial == sw($past(lane_in.tx_parallel))) else $error("transmit swap wrong");
  a_relay_ace_route: assert property (ok && $past(pins.relay_pin_ace, 3) && !$past(pins.pattern_test_enable_pin, 3) |->
    {lane_out.tx_serial[4], lane_out.tx_serial[2], lane_out.tx_serial[0]} ==
    $past({lane_in.rx_serial[5], lane_in.rx_serial[3], lane_in.rx_serial[1]})) else $error("relay onto A C E wrong");
  a_relay_bdf_route: assert property (ok && $past(pins.relay_pin_bdf, 3) && !$past(pins.pattern_test_enable_pin, 3) |->
    {lane_out.tx_serial[5], lane_out.tx_serial[3], lane_out.tx_serial[1]} ==
    $past({lane_in.rx_serial[4], lane_in.rx_serial[2], lane_in.rx_serial[0]})) else $error("relay onto B D F wrong");
  a_comma_off_clear: assert property (ok && !$past(pins.comma_align_enable_pin, 3) |-> comma_locked == '0)
    else $error("lock shown with alignment off");
  a_sgmii_strap: assert property ($fell(reset) |-> ##2 sgmii_mode == $past(pins.sgmii_pin, 4))
    else $error("strap not latched at reset release");
  a_pattern_runs: assert property (pat_cnt == 5'h1f |-> run_len < 4'h8)
    else $error("pattern output has a run too long");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  c_swap: cover property (ok && $past(pins.swap_pin, 3));
  c_pattern: cover property (pat_cnt == 5'h1f);
  c_lock: cover property (comma_locked != '0);
endmodule : cmpc_sva
bind cmpc_top cmpc_sva #(.NCH(NCH)) u_sva (.mclk(mclk), .reset(reset), .pins(pins), .lane_in(lane_in),
  .lane_out(lane_out), .comma_locked(comma_locked), .sgmii_mode(sgmii_mode), .irq(irq),
  .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// file: verilog/cmpc_pkg.sv
// Package for the channel mode pin control block: register map, field layout, types.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus with 32-bit data.
package cmpc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int PRBS_ORDER = 7;
  localparam int PRBS_TAP = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [9:0] COMMA_POS = 10'h07c;
  localparam logic [6:0] COMMA_MASK7 = 7'h7f;
  localparam logic [6:0] COMMA_CODE7 = 7'h1f;
  localparam logic [PRBS_ORDER-1:0] PRBS_SEED = 7'h7f;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SWAP = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RELAY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PRBS_ERR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_PINS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_COMMA_BIT = 0;
  localparam int MODE_SGMII_BIT = 4;
  localparam int PINS_PRBS_BIT = 0;
  localparam int PINS_COMMA_BIT = 1;
  localparam int PINS_SWAP_BIT = 2;
  localparam int PINS_RELAY_ACE_BIT = 3;
  localparam int PINS_RELAY_BDF_BIT = 4;
  localparam int PINS_SGMII_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_COMMA_RST = 1'b1;
  localparam logic [NUM_CH/2-1:0] SWAP_RST = 3'h0;
  localparam logic [NUM_CH-1:0] RELAY_RST = 6'h00;
  localparam logic [NUM_CH-1:0] CH_ZERO = 6'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Board-level mode pins
  typedef struct packed {
    logic pattern_test_enable_pin;
    logic comma_align_enable_pin;
    logic swap_pin;
    logic relay_pin_ace;
    logic relay_pin_bdf;
    logic sgmii_pin;
  } cmpc_pins_t;

  // Per-channel serial datapath slice: one recovered bit and one parallel-side bit
  typedef struct packed {
    logic [NUM_CH-1:0] rx_serial;
    logic [NUM_CH-1:0] tx_parallel;
  } cmpc_lane_in_t;

  typedef struct packed {
    logic [NUM_CH-1:0] tx_serial;
    logic [NUM_CH-1:0] rx_parallel;
  } cmpc_lane_out_t;

  // Adjacent channel of a pair: A<->B, C<->D, E<->F
  function automatic int cmpc_partner(input int ch);
    return ch ^ 1;
  endfunction : cmpc_partner
endpackage : cmpc_pkg

// file: verilog/cmpc_prbs_lane.sv
// One channel's 2^7-1 pattern generator and checker.
// Assumes one serial bit per mclk cycle on each side.
`timescale 1ns/100ps
`default_nettype none
module cmpc_prbs_lane #(
  parameter int ORDER = 7,
  parameter int TAP = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic rx_bit,
  output var logic tx_bit,
  output var logic mismatch
);
  import cmpc_pkg::*;
  logic [ORDER-1:0] gen;
  logic [ORDER-1:0] chk;
  wire gen_fb = gen[ORDER-1] ^ gen[TAP-1];
  wire chk_pred = chk[ORDER-1] ^ chk[TAP-1];

  assign tx_bit = gen[ORDER-1];

  // Checker self-seeds from the incoming stream, so any lane skew is tolerated
  always_ff @(posedge mclk) begin
    if (reset || !enable) begin
      gen <= PRBS_SEED;
      chk <= PRBS_SEED;
      mismatch <= 1'b0;
    end else begin
      gen <= {gen[ORDER-2:0], gen_fb};
      chk <= {chk[ORDER-2:0], rx_bit};
      mismatch <= (chk_pred != rx_bit);
    end
  end
endmodule : cmpc_prbs_lane
`default_nettype wire

// file: verilog/cmpc_sync.sv
// Two-flop synchroniser for the board mode pins.
// Assumes pins are static straps or slow levels relative to mclk.
`timescale 1ns/100ps
`default_nettype none
module cmpc_sync #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  import cmpc_pkg::*;
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : cmpc_sync
`default_nettype wire

// file: verilog/cmpc_top.sv
// Channel mode pin control: pattern test, comma alignment, port swap, relay and SGMII strap.
// Assumes synchronous pins, a single AHB-Lite master and one serial bit per channel per cycle.
//
// Behaviour
// - Pattern pin high puts 2^7-1 generators on transmit and checkers on receive.
// - Each channel's pattern comparison result is readable by software.
// - With alignment on, each channel flags lock on positive-disparity commas 0011111 and restarts its symbol phase.
// - Alignment is enabled by alignment pin AND comma-detect register bit.
// - Swap routes B parallel to A serial and back; likewise C/D, E/F.
// - Swap is active when swap pin OR the pair's swap register bit set.
// - First relay pin retransmits B receive on A, D on C, F on E.
// - Relay onto A, C, E active when first relay pin OR channel bit set.
// - Second relay pin retransmits A receive on B, C on D, E on F.
// - Relay onto B, D, F active when second relay pin OR channel bit set.
// - SGMII pin level loaded into mode bit 4 when chip reset falls.
// - Chip reset clears the datapath and returns all flags to defaults.
`timescale 1ns/100ps
`default_nettype none
module cmpc_top #(
  parameter int NCH = cmpc_pkg::NUM_CH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire cmpc_pkg::cmpc_pins_t pins,
  input wire cmpc_pkg::cmpc_lane_in_t lane_in,
  output var cmpc_pkg::cmpc_lane_out_t lane_out,
  output var logic [NCH-1:0] comma_locked,
  output var logic sgmii_mode,
  output var logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic [31:0] hrdata,
  output var logic hreadyout,
  output var logic hresp
);
  import cmpc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  cmpc_pins_t pins_s;
  cmpc_sync #(.WIDTH($bits(cmpc_pins_t))) u_sync (
    .mclk(mclk),
    .reset(1'b0),
    .async_in(pins),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic comma_detect_bit;
  logic [NCH/2-1:0] swap_bits;
  logic [NCH-1:0] relay_bits;
  logic sgmii_bit;
  logic [NCH-1:0] prbs_err;
  logic [NCH-1:0] irq_stat;
  logic [NCH-1:0] irq_en;
  logic reset_d;

  // AHB address phase capture
  logic dp_valid;
  logic dp_write;
  logic [ADDR_W-1:0] dp_addr;
  wire take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire wr_now = dp_valid && dp_write;
  wire wr_ctrl = wr_now && dp_addr == REG_CTRL;
  wire wr_swap = wr_now && dp_addr == REG_SWAP;
  wire wr_relay = wr_now && dp_addr == REG_RELAY;
  wire wr_mode = wr_now && dp_addr == REG_MODE;
  wire wr_clr = wr_now && dp_addr == REG_IRQ_CLR;
  wire wr_en = wr_now && dp_addr == REG_IRQ_EN;

  // ----------------------------------------------------------------
  // Mode combination
  // ----------------------------------------------------------------
  wire prbs_on = pins_s.pattern_test_enable_pin;
  wire align_on = pins_s.comma_align_enable_pin && comma_detect_bit;
  logic [NCH-1:0] swap_ch;
  logic [NCH-1:0] relay_ch;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      swap_ch[c] = pins_s.swap_pin || swap_bits[c/2];
      if (c % 2 == 0) begin
        relay_ch[c] = pins_s.relay_pin_ace || relay_bits[c];
      end else begin
        relay_ch[c] = pins_s.relay_pin_bdf || relay_bits[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pattern lanes
  // ----------------------------------------------------------------
  logic [NCH-1:0] prbs_tx;
  logic [NCH-1:0] prbs_miss;
  for (genvar g = 0; g < NCH; g++) begin : g_lane
    cmpc_prbs_lane #(.ORDER(PRBS_ORDER), .TAP(PRBS_TAP)) u_lane (
      .mclk(mclk),
      .reset(reset),
      .enable(prbs_on),
      .rx_bit(lane_in.rx_serial[g]),
      .tx_bit(prbs_tx[g]),
      .mismatch(prbs_miss[g])
    );
  end

  // ----------------------------------------------------------------
  // Comma alignment: 10-bit window per channel, phase counter
  // ----------------------------------------------------------------
  logic [9:0] rx_win [NCH];
  logic [3:0] phase [NCH];
  wire [NCH-1:0] comma_hit;
  for (genvar g = 0; g < NCH; g++) begin : g_comma
    assign comma_hit[g] = (rx_win[g][9:3] & COMMA_MASK7) == COMMA_CODE7;
  end

  // ----------------------------------------------------------------
  // Routing: transmit pattern > relay > swap > normal; receive parallel by swap only
  // ----------------------------------------------------------------
  logic [NCH-1:0] next_tx;
  logic [NCH-1:0] next_rxp;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (prbs_on) begin
        next_tx[c] = prbs_tx[c];
      end else if (relay_ch[c]) begin
        next_tx[c] = lane_in.rx_serial[cmpc_partner(c)];
      end else if (swap_ch[c]) begin
        next_tx[c] = lane_in.tx_parallel[cmpc_partner(c)];
      end else begin
        next_tx[c] = lane_in.tx_parallel[c];
      end
      next_rxp[c] = swap_ch[c] ? lane_in.rx_serial[cmpc_partner(c)] : lane_in.rx_serial[c];
    end
  end

  // ----------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      lane_out <= '0;
      comma_locked <= CH_ZERO;
      for (int c = 0; c < NCH; c++) begin
        rx_win[c] <= '0;
        phase[c] <= '0;
      end
    end else begin
      lane_out.tx_serial <= next_tx;
      lane_out.rx_parallel <= next_rxp;
      for (int c = 0; c < NCH; c++) begin
        rx_win[c] <= {rx_win[c][8:0], lane_in.rx_serial[c]};
        // Comma restarts the symbol phase counter and sets the channel's lock flag
        if (align_on && comma_hit[c]) begin
          phase[c] <= '0;
          comma_locked[c] <= 1'b1;
        end else begin
          phase[c] <= (phase[c] == 4'h9) ? 4'h0 : phase[c] + 4'h1;
          if (!align_on) begin
            comma_locked[c] <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and SGMII strap
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    reset_d <= reset;
    if (reset) begin
      comma_detect_bit <= CTRL_COMMA_RST;
      swap_bits <= SWAP_RST;
      relay_bits <= RELAY_RST;
      prbs_err <= CH_ZERO;
      irq_stat <= CH_ZERO;
      irq_en <= CH_ZERO;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) comma_detect_bit <= hwdata[CTRL_COMMA_BIT];
      if (wr_swap) swap_bits <= hwdata[NCH/2-1:0];
      if (wr_relay) relay_bits <= hwdata[NCH-1:0];
      if (wr_en) irq_en <= hwdata[NCH-1:0];
      // Live mismatch flags, sticky copy for interrupt; set wins over clear
      prbs_err <= prbs_on ? prbs_miss : CH_ZERO;
      irq_stat <= (irq_stat & ~(wr_clr ? hwdata[NCH-1:0] : CH_ZERO)) | (prbs_on ? prbs_miss : CH_ZERO);
      irq <= |(irq_stat & irq_en);
    end
    // Strap caught at the first edge after reset falls
    if (reset_d && !reset) begin
      sgmii_bit <= pins_s.sgmii_pin;
    end else if (reset) begin
      sgmii_bit <= 1'b0;
    end else if (wr_mode) begin
      sgmii_bit <= hwdata[MODE_SGMII_BIT];
    end
    sgmii_mode <= reset ? 1'b0 : sgmii_bit;
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = WORD_ZERO;
    unique case (haddr[ADDR_W-1:0])
      REG_CTRL: rd_word[CTRL_COMMA_BIT] = comma_detect_bit;
      REG_SWAP: rd_word[NCH/2-1:0] = swap_bits;
      REG_RELAY: rd_word[NCH-1:0] = relay_bits;
      REG_MODE: rd_word[MODE_SGMII_BIT] = sgmii_bit;
      REG_PRBS_ERR: rd_word[NCH-1:0] = prbs_err;
      REG_IRQ_STAT: rd_word[NCH-1:0] = irq_stat;
      REG_IRQ_EN: rd_word[NCH-1:0] = irq_en;
      REG_PINS: begin
        rd_word[PINS_PRBS_BIT] = pins_s.pattern_test_enable_pin;
        rd_word[PINS_COMMA_BIT] = pins_s.comma_align_enable_pin;
        rd_word[PINS_SWAP_BIT] = pins_s.swap_pin;
        rd_word[PINS_RELAY_ACE_BIT] = pins_s.relay_pin_ace;
        rd_word[PINS_RELAY_BDF_BIT] = pins_s.relay_pin_bdf;
        rd_word[PINS_SGMII_BIT] = pins_s.sgmii_pin;
      end
      default: rd_word = WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= '0;
      hrdata <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_addr <= haddr[ADDR_W-1:0];
      // Read data registered at the address phase so it stands in the data phase
      if (take && !hwrite) hrdata <= rd_word;
    end
  end
endmodule : cmpc_top
`default_nettype wire
